// file: verilog/dite_map.svh
`ifndef DITE_MAP_SVH
`define DITE_MAP_SVH
// Functional notes
// - Eight independent input timing engines, each with its own timing and triggers.
// - Engines are shared with analog input; an engine claimed by analog cannot arm.
// - Lines are captured on the chosen rising or falling sample clock edge.
// - A sample clock edge while the FIFO is full raises an overflow flag.
// - Each sample clock edge stores one word holding every line of the task.
// - Sample clock source 0 is a divided timebase, internal or external; timebase never output.
// - Internal sample clock has selectable source and polarity.
// - External sample clock comes from a terminal or the analog comparison event.
// - Sample clock is inverted before it drives a function terminal.
// - Acquisition starts on the start trigger, or on software start without trigger.
// - Finite stops on count or reference trigger; continuous stops on software stop.
// - Internal sample clock allows a programmed delay from start to first sample.
// - Start trigger has selectable source and selectable active edge.
// - Start trigger drives a function terminal as an active-high pulse.
// - Single-point mode samples without buffering; only clock or change timing.
// - Single-point sample not read before the next one gives a late warning.
// - Arming a task mixing parallel and serial modules is rejected.
// - Serial modules cannot be trigger sources.
// - A serial module busy with static work cannot join a timed task.
// - A bidirectional serial module allows timed work in one direction only.
// - Static lines are read and written by software, direction per line.

// ==================== Address map
`define DITE_ENGINES 8
`define DITE_LINES 32
`define DITE_SLOTS 8
`define DITE_FIFO_DEPTH 4
`define DITE_GLOBAL_BIT 8
`define DITE_REG_CTRL 3'h0
`define DITE_REG_CFG 3'h1
`define DITE_REG_DIV 3'h2
`define DITE_REG_COUNT 3'h3
`define DITE_REG_DELAY 3'h4
`define DITE_REG_STAT 3'h5
`define DITE_REG_DATA 3'h6
`define DITE_REG_MASK 3'h7
`define DITE_GREG_DIR 3'h0
`define DITE_GREG_OUT 3'h1
`define DITE_GREG_IN 3'h2
`define DITE_GREG_CLAIM 3'h3

// ==================== Fields
`define DITE_CTRL_ARM 0
`define DITE_CTRL_START 1
`define DITE_CTRL_STOP 2
`define DITE_STAT_OVF 0
`define DITE_STAT_LATE 1
`define DITE_STAT_REJ 2
`define DITE_STAT_DONE 3
`define DITE_MODE_FINITE 2'h0
`define DITE_MODE_CONT 2'h1
`define DITE_MODE_TSP 2'h2
`define DITE_TIMING_CLOCK 2'h0
`define DITE_TIMING_CHANGE 2'h1
`define DITE_FIRST_EXT_SRC 3'h6
`endif

// file: verilog/dite_pkg.sv
package dite_pkg;
  // ==================== Types
  typedef struct packed {
    logic [11:0] spare;
    logic ref_stop;
    logic [3:0] trig_src;
    logic trig_fall;
    logic trig_en;
    logic [2:0] term_sel;
    logic tb_ext;
    logic clk_inv;
    logic [2:0] clk_src;
    logic smp_fall;
    logic [1:0] timing;
    logic [1:0] mode;
  } dite_cfg_t;

  typedef enum logic [1:0] {
    DITE_IDLE = 2'b00,
    DITE_ARMED = 2'b01,
    DITE_DELAY = 2'b10,
    DITE_RUN = 2'b11
  } dite_state_t;
endpackage : dite_pkg

// file: verilog/dite_top.sv
`timescale 1ns/1ps
`include "dite_map.svh"

// ==================== One timing engine
module dite_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register access
  input wire logic wr_en,
  input wire logic rd_pop,
  input wire logic [2:0] reg_sel,
  input wire logic [31:0] wdata,
  output logic [31:0] rd_word,
  // Timing sources
  input wire logic timebase_int,
  input wire logic timebase_ext,
  input wire logic [7:0] term_in,
  input wire logic peer_sample,
  input wire logic out_engine_clock,
  input wire logic counter_out,
  input wire logic freq_out,
  input wire logic change_detect,
  input wire logic analog_compare,
  input wire logic reference_trigger,
  input wire logic integrated_trigger,
  input wire logic [7:0] slot_trigger,
  // Modules
  input wire logic [31:0] lines,
  input wire logic [7:0] module_serial,
  input wire logic [7:0] module_bidir,
  input wire logic [7:0] static_busy,
  input wire logic [7:0] out_hw_busy,
  input wire logic ai_claim,
  // Outputs
  output logic sample_level,
  output logic sample_term,
  output logic start_term,
  output logic claim,
  output logic [7:0] module_hold
);
  dite_pkg::dite_cfg_t cfg;
  dite_pkg::dite_state_t state;
  logic [15:0] div;
  logic [15:0] div_cnt;
  logic div_level;
  logic [31:0] count;
  logic [31:0] taken;
  logic [15:0] delay;
  logic [15:0] dly_cnt;
  logic [7:0] mask;
  logic [3:0] flags;
  logic tb_q, clk_q, trig_q, cd_q, ref_q;
  logic [31:0] mem [0:`DITE_FIFO_DEPTH-1];
  logic [1:0] wp, rp;
  logic [2:0] fifo_cnt;
  logic [31:0] point;
  logic point_valid;

  // ==================== Source selection
  wire tb = cfg.tb_ext ? timebase_ext : timebase_int;
  wire tb_tick = tb & ~tb_q;
  wire [7:0] src_vec = {analog_compare, term_in[cfg.term_sel], change_detect, freq_out,
                        counter_out, out_engine_clock, peer_sample, div_level};
  wire internal = cfg.clk_src < `DITE_FIRST_EXT_SRC;
  wire clk_lvl = src_vec[cfg.clk_src] ^ (internal & cfg.clk_inv);
  wire clk_edge = cfg.smp_fall ? (~clk_lvl & clk_q) : (clk_lvl & ~clk_q);
  wire cd_edge = change_detect & ~cd_q;
  wire ref_edge = reference_trigger & ~ref_q;
  wire [15:0] trig_vec = {6'h00, counter_out, slot_trigger, integrated_trigger};
  wire trig_lvl = trig_vec[cfg.trig_src];
  wire trig_edge = cfg.trig_fall ? (~trig_lvl & trig_q) : (trig_lvl & ~trig_q);
  wire [3:0] trig_slot = cfg.trig_src - 4'h1;
  wire trig_serial = (cfg.trig_src != 4'h0) && (cfg.trig_src <= 4'h8) && module_serial[trig_slot[2:0]];

  // ==================== Arm checks
  wire mixed = (|(mask & module_serial)) && (|(mask & ~module_serial));
  wire trig_bad = cfg.trig_en && trig_serial;
  wire static_conf = |(mask & module_serial & static_busy);
  wire dir_conf = |(mask & module_serial & module_bidir & out_hw_busy);
  wire tsp_bad = (cfg.mode == `DITE_MODE_TSP) && (cfg.timing != `DITE_TIMING_CLOCK)
                 && (cfg.timing != `DITE_TIMING_CHANGE);
  wire reject = mixed | trig_bad | static_conf | dir_conf | tsp_bad | ai_claim;

  // ==================== Control decode
  wire ctrl_wr = wr_en && (reg_sel == `DITE_REG_CTRL);
  wire arm_wr = ctrl_wr && wdata[`DITE_CTRL_ARM] && (state == dite_pkg::DITE_IDLE);
  wire start_wr = ctrl_wr && wdata[`DITE_CTRL_START];
  wire stop_wr = ctrl_wr && wdata[`DITE_CTRL_STOP];
  wire stat_clr = wr_en && (reg_sel == `DITE_REG_STAT);
  wire finite = cfg.mode == `DITE_MODE_FINITE;
  wire tsp = cfg.mode == `DITE_MODE_TSP;
  wire count_hit = finite && (taken >= count);
  wire start_evt = (state == dite_pkg::DITE_ARMED) && (cfg.trig_en ? trig_edge : start_wr);
  wire go_delay = internal && (delay != 16'h0000);
  wire sample_evt = (state == dite_pkg::DITE_RUN) && !count_hit
                    && ((cfg.timing == `DITE_TIMING_CHANGE) ? cd_edge : clk_edge);
  wire full = fifo_cnt == `DITE_FIFO_DEPTH;
  wire empty = fifo_cnt == 3'h0;
  wire data_rd = rd_pop && (reg_sel == `DITE_REG_DATA);
  wire push = sample_evt && !tsp && !full;
  wire pop = data_rd && !tsp && !empty;
  wire overflow = sample_evt && !tsp && full;
  wire late = sample_evt && tsp && point_valid;
  wire run_end = (state == dite_pkg::DITE_RUN) && (count_hit || (finite && cfg.ref_stop && ref_edge));
  wire [31:0] task_mask;
  wire [31:0] sample_word = lines & task_mask;
  wire [3:0] flag_set = {run_end, arm_wr & reject, late, overflow};

  genvar s;
  for (s = 0; s < `DITE_SLOTS; s++) begin : g_mask
    assign task_mask[s*4 +: 4] = {4{mask[s]}};
  end

  // Register read mux
  assign rd_word = (reg_sel == `DITE_REG_CTRL) ? {30'h0, state} :
                   (reg_sel == `DITE_REG_CFG) ? cfg :
                   (reg_sel == `DITE_REG_DIV) ? {16'h0000, div} :
                   (reg_sel == `DITE_REG_COUNT) ? count :
                   (reg_sel == `DITE_REG_DELAY) ? {16'h0000, delay} :
                   (reg_sel == `DITE_REG_STAT) ? {25'h0, fifo_cnt, flags} :
                   (reg_sel == `DITE_REG_DATA) ? (tsp ? point : mem[rp]) :
                   {24'h0, mask};
  assign claim = state != dite_pkg::DITE_IDLE;
  assign module_hold = claim ? mask : 8'h00;
  assign sample_level = clk_q;
  assign sample_term = ~clk_q;

  // Configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg <= '0;
      div <= 16'h0000;
      count <= 32'h0;
      delay <= 16'h0000;
      mask <= 8'h00;
    end else if (wr_en && (state == dite_pkg::DITE_IDLE)) begin
      if (reg_sel == `DITE_REG_CFG) cfg <= wdata;
      if (reg_sel == `DITE_REG_DIV) div <= wdata[15:0];
      if (reg_sel == `DITE_REG_COUNT) count <= wdata;
      if (reg_sel == `DITE_REG_DELAY) delay <= wdata[15:0];
      if (reg_sel == `DITE_REG_MASK) mask <= wdata[7:0];
    end
  end

  // Edge history, shared by all detectors
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {tb_q, clk_q, trig_q, cd_q, ref_q} <= 5'h00;
    end else begin
      {tb_q, clk_q, trig_q, cd_q, ref_q} <= {tb, clk_lvl, trig_lvl, change_detect, reference_trigger};
    end
  end

  // Timebase divider, stopped outside a run so each run starts in phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt <= 16'h0000;
      div_level <= 1'b0;
    end else if (state != dite_pkg::DITE_RUN) begin
      div_cnt <= 16'h0000;
      div_level <= 1'b0;
    end else if (tb_tick) begin
      if (div_cnt >= div) begin
        div_cnt <= 16'h0000;
        div_level <= ~div_level;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // Engine sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= dite_pkg::DITE_IDLE;
      dly_cnt <= 16'h0000;
      start_term <= 1'b0;
    end else begin
      start_term <= start_evt;
      case (state)
        dite_pkg::DITE_IDLE: begin
          if (arm_wr && !reject) state <= dite_pkg::DITE_ARMED;
        end
        dite_pkg::DITE_ARMED: begin
          if (stop_wr) begin
            state <= dite_pkg::DITE_IDLE;
          end else if (start_evt) begin
            dly_cnt <= delay;
            state <= go_delay ? dite_pkg::DITE_DELAY : dite_pkg::DITE_RUN;
          end
        end
        dite_pkg::DITE_DELAY: begin
          if (stop_wr) begin
            state <= dite_pkg::DITE_IDLE;
          end else if (tb_tick) begin
            if (dly_cnt <= 16'h0001) state <= dite_pkg::DITE_RUN;
            dly_cnt <= dly_cnt - 16'h0001;
          end
        end
        dite_pkg::DITE_RUN: begin
          if (stop_wr || run_end) state <= dite_pkg::DITE_IDLE;
        end
        default: state <= dite_pkg::DITE_IDLE;
      endcase
    end
  end

  // Sample count and sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      taken <= 32'h0;
      flags <= 4'h0;
    end else begin
      if (arm_wr) taken <= 32'h0;
      else if (sample_evt) taken <= taken + 32'h1;
      flags <= (flags & ~(stat_clr ? wdata[3:0] : 4'h0)) | flag_set;
    end
  end

  // Acquisition FIFO, emptied on arm
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp <= 2'h0;
      rp <= 2'h0;
      fifo_cnt <= 3'h0;
    end else if (arm_wr) begin
      wp <= 2'h0;
      rp <= 2'h0;
      fifo_cnt <= 3'h0;
    end else begin
      if (push) wp <= wp + 2'h1;
      if (pop) rp <= rp + 2'h1;
      fifo_cnt <= fifo_cnt + {2'h0, push} - {2'h0, pop};
    end
  end

  // Storage has no reset; only pointers define contents
  always_ff @(posedge clk) begin
    if (push) mem[wp] <= sample_word;
  end

  // Single-point holding word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      point <= 32'h0;
      point_valid <= 1'b0;
    end else if (sample_evt && tsp) begin
      point <= sample_word;
      point_valid <= 1'b1;
    end else if (data_rd || arm_wr) begin
      point_valid <= 1'b0;
    end
  end

  // ==================== Assertions
  a_fifo_overflow: assert property (@(posedge clk) disable iff (reset)
    sample_evt && full && !tsp |=> flags[`DITE_STAT_OVF]) else $error("overflow not flagged");
  a_one_word_sample: assert property (@(posedge clk) disable iff (reset)
    push && !pop && !arm_wr |=> fifo_cnt == $past(fifo_cnt) + 3'h1) else $error("sample not stored");
  a_term_inverted: assert property (@(posedge clk) disable iff (reset)
    $rose(clk_lvl) |=> $fell(sample_term)) else $error("terminal clock not inverted");
  a_start_pulse: assert property (@(posedge clk) disable iff (reset)
    start_evt |=> start_term ##1 !start_term) else $error("start pulse wrong");
  a_reject_arm: assert property (@(posedge clk) disable iff (reset)
    arm_wr && reject |=> state == dite_pkg::DITE_IDLE && flags[`DITE_STAT_REJ]) else $error("bad arm accepted");
  a_tsp_unbuffered: assert property (@(posedge clk) disable iff (reset)
    tsp && !arm_wr && !pop |=> $stable(fifo_cnt)) else $error("single point buffered");
  a_late_warning: assert property (@(posedge clk) disable iff (reset)
    late |=> flags[`DITE_STAT_LATE] && point_valid) else $error("late read not warned");
  a_finite_stop: assert property (@(posedge clk) disable iff (reset)
    state == dite_pkg::DITE_RUN && count_hit |=> state == dite_pkg::DITE_IDLE) else $error("finite run overran");
  a_soft_start: assert property (@(posedge clk) disable iff (reset)
    state == dite_pkg::DITE_ARMED && !cfg.trig_en && start_wr && !stop_wr
    |=> state inside {dite_pkg::DITE_DELAY, dite_pkg::DITE_RUN}) else $error("software start ignored");
endmodule : dite_engine

// ==================== Top: register port, static lines, engine pool
module dite_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [8:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Timing sources
  input wire logic timebase_int,
  input wire logic timebase_ext,
  input wire logic [7:0] programmable_function_terminal_in,
  input wire logic output_engine_sample_clock,
  input wire logic counter_out,
  input wire logic freq_out,
  input wire logic change_detect,
  input wire logic analog_compare,
  input wire logic reference_trigger,
  input wire logic integrated_trigger,
  input wire logic [7:0] slot_trigger,
  // Modules
  input wire logic [31:0] digital_line_in,
  output logic [31:0] digital_line_out,
  output logic [31:0] digital_line_oe,
  input wire logic [7:0] module_serial,
  input wire logic [7:0] module_bidir,
  input wire logic [7:0] static_busy,
  input wire logic [7:0] out_hw_busy,
  input wire logic [7:0] ai_claim,
  // Engine outputs
  output logic [7:0] input_engine_sample_clock,
  output logic [7:0] sample_clock_term,
  output logic [7:0] start_trigger_term,
  output logic [7:0] engine_claim,
  output logic [7:0] module_hw_input_busy
);
  logic [31:0] static_dir;
  logic [31:0] static_out;
  logic [31:0] eng_word [0:`DITE_ENGINES-1];
  logic [7:0] hold [0:`DITE_ENGINES-1];

  // Address decode
  wire global_sel = addr[`DITE_GLOBAL_BIT];
  wire [2:0] eng_sel = addr[7:5];
  wire [2:0] reg_sel = addr[4:2];
  wire g_wr = wr && global_sel;
  wire [31:0] g_word = (reg_sel == `DITE_GREG_DIR) ? static_dir :
                       (reg_sel == `DITE_GREG_OUT) ? static_out :
                       (reg_sel == `DITE_GREG_IN) ? digital_line_in :
                       (reg_sel == `DITE_GREG_CLAIM) ? {24'h0, engine_claim} : 32'h0;
  wire [31:0] next_rdata = !rd ? 32'h0 : global_sel ? g_word : eng_word[eng_sel];

  // Eight engines form the shared pool
  genvar e;
  for (e = 0; e < `DITE_ENGINES; e++) begin : g_eng
    dite_engine u_eng (
      .clk(clk),
      .reset(reset),
      .wr_en(wr && !global_sel && (eng_sel == e)),
      .rd_pop(rd && !global_sel && (eng_sel == e)),
      .reg_sel(reg_sel),
      .wdata(wdata),
      .rd_word(eng_word[e]),
      .timebase_int(timebase_int),
      .timebase_ext(timebase_ext),
      .term_in(programmable_function_terminal_in),
      .peer_sample(input_engine_sample_clock[(e + 1) % `DITE_ENGINES]),
      .out_engine_clock(output_engine_sample_clock),
      .counter_out(counter_out),
      .freq_out(freq_out),
      .change_detect(change_detect),
      .analog_compare(analog_compare),
      .reference_trigger(reference_trigger),
      .integrated_trigger(integrated_trigger),
      .slot_trigger(slot_trigger),
      .lines(digital_line_in),
      .module_serial(module_serial),
      .module_bidir(module_bidir),
      .static_busy(static_busy),
      .out_hw_busy(out_hw_busy),
      .ai_claim(ai_claim[e]),
      .sample_level(input_engine_sample_clock[e]),
      .sample_term(sample_clock_term[e]),
      .start_term(start_trigger_term[e]),
      .claim(engine_claim[e]),
      .module_hold(hold[e])
    );
  end

  // Modules held by any input engine that is not idle (armed, delaying or running)
  always_comb begin
    module_hw_input_busy = 8'h00;
    for (int i = 0; i < `DITE_ENGINES; i++) module_hw_input_busy = module_hw_input_busy | hold[i];
  end

  assign digital_line_out = static_out;
  assign digital_line_oe = static_dir;

  // Static line registers, software timed only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      static_dir <= 32'h0;
      static_out <= 32'h0;
      rdata <= 32'h0;
    end else begin
      rdata <= next_rdata;
      if (g_wr && (reg_sel == `DITE_GREG_DIR)) static_dir <= wdata;
      if (g_wr && (reg_sel == `DITE_GREG_OUT)) static_out <= wdata;
    end
  end
endmodule : dite_top

// file: testbench/dite_mod_model.sv
`timescale 1ns/1ps

// ==================== Plug-in module and timebase stand-in
module dite_mod_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // New line pattern
  input wire logic load,
  input wire logic [31:0] load_value,
  // Module pins and timebase
  output logic [31:0] lines,
  output logic timebase
);
  // Lines hold still between loads, so no sample edge straddles a change
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lines <= 32'h0;
      timebase <= 1'b0;
    end else begin
      timebase <= ~timebase; // Tick every second cycle keeps delays short
      if (load) begin
        lines <= load_value;
      end
    end
  end
endmodule : dite_mod_model

// file: testbench/tb_digital_input_timing_engine.sv
`timescale 1ns/1ps
`include "dite_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

// ==================== Bench top
module tb_digital_input_timing_engine;
  localparam logic [2:0] CTRL = `DITE_REG_CTRL, CFG = `DITE_REG_CFG, DIV = `DITE_REG_DIV, CNT = `DITE_REG_COUNT;
  localparam logic [2:0] DLY = `DITE_REG_DELAY, STAT = `DITE_REG_STAT, DATA = `DITE_REG_DATA, MASK = `DITE_REG_MASK;
  localparam logic [2:0] EXT = `DITE_FIRST_EXT_SRC;
  logic clk, reset, wr, rd, load, tbase, ext_clock, ref_trig;
  logic [8:0] addr;
  logic [31:0] wdata, rdata, lines, next_lines, rv, exp_v, dir_v, out_v, dout, doe;
  logic [7:0] slot_trigger, ser, bid, sbusy, obusy, ai, isc, scp, stp, claim, hwbusy;
  logic [6:0] noise, noise_term;
  logic [3:0] hits;
  logic [31:0] q[$];
  int mismatches, n_compared, eng;

  dite_mod_model modules (.clk(clk), .reset(reset), .load(load), .load_value(next_lines),
    .lines(lines), .timebase(tbase));

  dite_top dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .timebase_int(tbase), .timebase_ext(noise[6]), .programmable_function_terminal_in({noise_term, ext_clock}),
    .output_engine_sample_clock(noise[5]), .counter_out(noise[4]), .freq_out(noise[3]),
    .change_detect(noise[2]), .analog_compare(noise[1]), .reference_trigger(ref_trig),
    .integrated_trigger(noise[0]), .slot_trigger(slot_trigger), .digital_line_in(lines),
    .digital_line_out(dout), .digital_line_oe(doe), .module_serial(ser), .module_bidir(bid),
    .static_busy(sbusy), .out_hw_busy(obusy), .ai_claim(ai), .input_engine_sample_clock(isc),
    .sample_clock_term(scp), .start_trigger_term(stp), .engine_claim(claim), .module_hw_input_busy(hwbusy));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Unselected sources toggle so a wrong selection shows up
  always @(posedge clk) {noise, noise_term} <= 14'($urandom);

  // Config word in the field order of the package struct
  function automatic logic [31:0] cfg(input logic [1:0] mode, timing, input logic fall, input logic [2:0] src,
    input logic ten, tfall, input logic [3:0] tsrc);
    cfg = {13'h0, tsrc, tfall, ten, 5'h0, src, fall, timing, mode};
  endfunction : cfg

  // Register port cycles for the current engine
  task automatic w(input logic [2:0] r, input logic [31:0] d);
    @(posedge clk);
    addr <= {1'b0, eng[2:0], r, 2'b00};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : w

  task automatic rda(input logic [8:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask : rda

  task automatic r(input logic [2:0] g);
    rda({1'b0, eng[2:0], g, 2'b00});
  endtask : r

  // One sample clock pulse on terminal 0; lines steady across both edges
  task automatic pulse(input bit keep);
    @(posedge clk);
    next_lines = $urandom;
    load <= 1'b1;
    if (keep) q.push_back(next_lines);
    @(posedge clk);
    load <= 1'b0;
    repeat (2) @(posedge clk);
    ext_clock <= 1'b1;
    repeat (5) @(posedge clk);
    ext_clock <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : pulse

  task automatic drain;
    while (q.size() > 0) begin
      r(DATA);
      exp_v = q.pop_front();
      `CHK(rv, exp_v)
    end
  endtask : drain

  // Arm engine 5 under one module mix; a refused arm leaves it idle
  task automatic try_arm(input logic [31:0] c, input logic [7:0] m, s, b, sb, ob, a, input logic rej);
    ser <= s;
    bid <= b;
    sbusy <= sb;
    obusy <= ob;
    ai <= a;
    eng = 5;
    w(CFG, c);
    w(MASK, {24'h0, m});
    w(CTRL, 32'h1);
    r(STAT);
    `CHK(rv[2], rej)
    `CHK(claim[5], ~rej)
    `CHK(hwbusy, rej ? 8'h00 : m)
    w(STAT, 32'hf);
    w(CTRL, 32'h4);
  endtask : try_arm

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(58591));
    {reset, wr, rd, load, ext_clock, ref_trig} = 6'h20;
    {addr, wdata, next_lines, slot_trigger, ser, bid, sbusy, obusy, ai} = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    eng = 0;
    r(CTRL);
    `CHK(rv[1:0], 2'h0)
    r(STAT);
    `CHK(rv, 32'h0)
    `CHK(claim, 8'h00)
    `CHK(scp, ~isc)
    // Static lines through the global registers
    dir_v = $urandom;
    out_v = $urandom;
    rda(9'h100);
    @(posedge clk);
    next_lines = $urandom;
    load <= 1'b1;
    addr <= 9'h100;
    wdata <= dir_v;
    wr <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    addr <= 9'h104;
    wdata <= out_v;
    @(posedge clk);
    wr <= 1'b0;
    rda(9'h108);
    `CHK(rv, lines)
    `CHK(doe, dir_v)
    `CHK(dout, out_v)
    rda(9'h110);
    `CHK(rv, 32'h0)
    // Finite run of three samples on every engine; a fourth edge is ignored
    for (eng = 0; eng < 8; eng++) begin
      w(CFG, cfg(`DITE_MODE_FINITE, `DITE_TIMING_CLOCK, 1'b0, EXT, 1'b0, 1'b0, 4'h0));
      w(CNT, 32'h3);
      w(MASK, 32'hff);
      w(CTRL, 32'h1);
      w(CTRL, 32'h2);
      @(negedge clk);
      `CHK(claim, 8'(1 << eng))
      repeat (4) pulse(q.size() < 3);
      r(STAT);
      `CHK(rv, 32'h38)
      r(CTRL);
      `CHK(rv[1:0], 2'h0)
      drain();
      w(STAT, 32'hf);
    end
    // Falling edge, continuous, five edges into a four-deep FIFO
    eng = 0;
    w(CFG, cfg(`DITE_MODE_CONT, `DITE_TIMING_CLOCK, 1'b1, EXT, 1'b0, 1'b0, 4'h0));
    w(CTRL, 32'h1);
    w(CTRL, 32'h2);
    repeat (5) pulse(q.size() < 4);
    r(STAT);
    `CHK(rv[0], 1'b1)
    `CHK(rv[6:4], 3'h4)
    w(CTRL, 32'h4);
    r(CTRL);
    `CHK(rv[1:0], 2'h0)
    drain();
    w(STAT, 32'hf);
    // Single point: an unread word overtaken gives the late warning
    eng = 2;
    w(CFG, cfg(`DITE_MODE_TSP, `DITE_TIMING_CLOCK, 1'b0, EXT, 1'b0, 1'b0, 4'h0));
    w(CTRL, 32'h1);
    w(CTRL, 32'h2);
    pulse(1'b1);
    drain();
    r(STAT);
    `CHK(rv[1], 1'b0)
    pulse(1'b0);
    pulse(1'b0);
    r(STAT);
    `CHK(rv[1], 1'b1)
    w(CTRL, 32'h4);
    w(STAT, 32'hf);
    // Finite run cut short by the reference trigger after one sample
    eng = 1;
    w(CFG, cfg(`DITE_MODE_FINITE, `DITE_TIMING_CLOCK, 1'b0, EXT, 1'b0, 1'b0, 4'h0) | 32'h0008_0000);
    w(CTRL, 32'h1);
    w(CTRL, 32'h2);
    pulse(1'b1);
    ref_trig <= 1'b1;
    @(posedge clk);
    ref_trig <= 1'b0;
    r(CTRL);
    `CHK(rv[1:0], 2'h0)
    r(STAT);
    `CHK(rv, 32'h18)
    drain();
    w(STAT, 32'hf);
    // Start trigger from slot 0, rising then falling
    eng = 4;
    for (int f = 0; f < 2; f++) begin
      slot_trigger <= {7'h0, f[0]};
      w(CFG, cfg(`DITE_MODE_CONT, `DITE_TIMING_CLOCK, 1'b0, EXT, 1'b1, f[0], 4'h1));
      w(CTRL, 32'h1);
      r(CTRL);
      `CHK(rv[1:0], 2'h1)
      @(posedge clk);
      slot_trigger <= {7'h0, ~f[0]};
      hits = 4'h0;
      repeat (10) begin
        @(negedge clk);
        hits = hits + {3'h0, stp[4]};
      end
      `CHK(hits, 4'h1)
      r(CTRL);
      `CHK(rv[1:0], 2'h3)
      w(CTRL, 32'h4);
    end
    // Internal divided clock with a start delay
    eng = 6;
    w(DIV, 32'h1);
    w(DLY, 32'h20);
    w(CFG, cfg(`DITE_MODE_CONT, `DITE_TIMING_CLOCK, 1'b0, 3'h0, 1'b0, 1'b0, 4'h0));
    w(CTRL, 32'h1);
    w(CTRL, 32'h2);
    r(CTRL);
    `CHK(rv[1:0], 2'h2)
    repeat (200) @(posedge clk);
    r(CTRL);
    `CHK(rv[1:0], 2'h3)
    // Half period is DIV+1 ticks, a tick every second cycle
    @(posedge isc[6]);
    hits = 4'h0;
    @(negedge clk);
    while (isc[6]) begin
      hits = hits + 4'h1;
      @(negedge clk);
    end
    `CHK(hits, 4'h4)
    repeat (8) begin
      repeat (3) @(negedge clk);
      `CHK(scp[6], ~isc[6])
    end
    w(CTRL, 32'h4);
    // Module mixes that must be refused, then one that is accepted
    try_arm(32'h0, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    try_arm(cfg(2'h1, 2'h0, 1'b0, EXT, 1'b1, 1'b0, 4'h2), 8'h01, 8'h02, 8'h0, 8'h0, 8'h0, 8'h0, 1'b1);
    try_arm(32'h0, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 1'b1);
    try_arm(32'h0, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00, 1'b1);
    try_arm(cfg(`DITE_MODE_TSP, 2'h2, 1'b0, EXT, 1'b0, 1'b0, 4'h0), 8'h01, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 1'b1);
    try_arm(32'h0, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 1'b1);
    try_arm(32'h0, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    print_verdict();
  end
endmodule : tb_digital_input_timing_engine
